//--- verilog/phcd_top.sv
/*
  phcd_top: pcm highway clock configuration with a classic wishbone slave.
  assumes pins synchronous to clk_i, a single-word bus master, 20 MHz clock.
*/
// Implementation choice: the Wishbone register port.
// Behaviour
// - with autodetect set, measure bit clock against frame sync and store the code
// - writing autodetect one restarts detection and reloads the default code
// - code is bit clock frequency over 8 kHz, minus one
// - highway A keeps the default code until both inputs toggle
// - highway A detection completes after nine consistent frame periods
// - redundant highway keeps the default code until both inputs toggle
// - redundant highway detection completes after nine consistent frame periods
// - A auto switch moves to redundant when A fails and B does not
// - with A auto switch clear, no automatic switch on A failure
// - generation bit selects pin frame sync or internally generated frame sync
// - read-only failure flag per highway shows bit clock loss
// - active highway bit is writable and hardware updates it on switch
`timescale 1ns/1ns
module phcd_top
  import phcd_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [7:0] adr_i, // wishbone byte address
  input wire logic [31:0] dat_i, // wishbone write data
  input wire logic [3:0] sel_i, // wishbone byte selects
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic highway_a_bit_clock_i, // highway A bit clock
  input wire logic highway_a_frame_sync_i, // highway A frame sync in
  output logic highway_a_frame_sync_o, // highway A frame sync out
  output logic highway_a_frame_sync_oe_o, // highway A frame sync drive
  input wire logic redundant_bit_clock_i, // redundant bit clock
  input wire logic redundant_frame_sync_i, // redundant frame sync in
  output logic redundant_frame_sync_o, // redundant frame sync out
  output logic redundant_frame_sync_oe_o, // redundant frame sync drive
  output logic active_highway_o, // 0 highway A, 1 redundant
  output logic a_clock_fail_flag_o, // highway A bit clock lost
  output logic b_clock_fail_flag_o // redundant bit clock lost
);
  import phcd_pkg::*;

  // index 0 is highway A, index 1 the redundant highway
  phcd_sel_t sel_ff [2];
  phcd_det_t det [2];
  logic [1:0] restart;
  logic [1:0] bclk;
  logic [1:0] fs_in;
  logic [1:0] fs_out;
  logic [1:0] fs_oe;
  logic active_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic req;
  logic wr_stb;
  logic [7:0] idx;
  logic [15:0] rd_word;
  logic [15:0] cur_word;
  logic [15:0] nxt_word;
  logic switch_to_b;
  logic switch_to_a;

  assign bclk = {redundant_bit_clock_i, highway_a_bit_clock_i};
  assign fs_in = {redundant_frame_sync_i, highway_a_frame_sync_i};

  // bus decode; the master holds the request until ack, so writes land on ack
  assign req = cyc_i & stb_i;
  assign wr_stb = req & we_i & ack_ff;
  assign idx = {2'b00, adr_i[7:2]};

  always_comb
  begin
    rd_word = 16'h0000;
    unique case (idx)
      IDX_A_SEL: rd_word = sel_ff[0];
      IDX_B_SEL: rd_word = sel_ff[1];
      IDX_STAT:
      begin
        rd_word[STAT_FAIL_A_BIT] = det[0].fail;
        rd_word[STAT_FAIL_B_BIT] = det[1].fail;
      end
      IDX_MCLK: rd_word[MCLK_ACTIVE_BIT] = active_ff;
      default: rd_word = 16'h0000;
    endcase
  end

  // byte lanes 0 and 1 carry the 16-bit registers
  always_comb
  begin
    cur_word = rd_word;
    nxt_word = cur_word;
    if (sel_i[0])
    begin
      nxt_word[7:0] = dat_i[7:0];
    end
    if (sel_i[1])
    begin
      nxt_word[15:8] = dat_i[15:8];
    end
  end

  // one wait state: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      if (req && !ack_ff)
      begin
        dat_ff <= {16'h0000, rd_word};
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  genvar h;
  generate
    for (h = 0; h < 2; h++)
    begin : g_hwy
      logic hit;
      phcd_sel_t wsel;

      assign hit = wr_stb && idx == ((h == 0) ? IDX_A_SEL : IDX_B_SEL);
      assign wsel = nxt_word;
      // any write carrying autodetect one on byte lane 1 restarts the measurement
      assign restart[h] = hit && wsel.autodet && sel_i[1];

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sel_ff[h] <= SEL_RESET;
        end
        else if (hit)
        begin
          sel_ff[h] <= wsel;
          if (wsel.autodet)
          begin
            sel_ff[h].freq <= FREQ_DEFAULT;
          end
        end
        else if (sel_ff[h].autodet && det[h].load)
        begin
          sel_ff[h].freq <= det[h].code;
        end
      end

      phcd_hwy_detect u_det (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bclk_i(bclk[h]),
        .fs_ext_i(fs_in[h]),
        .cfg_i(sel_ff[h]),
        .restart_i(restart[h]),
        .fs_o(fs_out[h]),
        .fs_oe_o(fs_oe[h]),
        .det_o(det[h])
      );
    end
  endgenerate

  // automatic highway switch; hardware wins over a same-cycle software write
  assign switch_to_b = sel_ff[0].auto_sw && !active_ff
                       && det[0].fail && !det[1].fail;
  assign switch_to_a = sel_ff[1].auto_sw && active_ff
                       && det[1].fail && !det[0].fail;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_ff <= ACTIVE_RESET;
    end
    else if (switch_to_b)
    begin
      active_ff <= 1'b1;
    end
    else if (switch_to_a)
    begin
      active_ff <= 1'b0;
    end
    else if (wr_stb && idx == IDX_MCLK && sel_i[1])
    begin
      active_ff <= dat_i[MCLK_ACTIVE_BIT];
    end
  end

  assign highway_a_frame_sync_o = fs_out[0];
  assign highway_a_frame_sync_oe_o = fs_oe[0];
  assign redundant_frame_sync_o = fs_out[1];
  assign redundant_frame_sync_oe_o = fs_oe[1];
  assign active_highway_o = active_ff;
  assign a_clock_fail_flag_o = det[0].fail;
  assign b_clock_fail_flag_o = det[1].fail;

endmodule // phcd_top

//--- common/phcd_pkg.sv
/*
  phcd_pkg: constants and carrier types for the pcm highway clock detect block.
  assumes a 20 MHz system clock and a 32-bit classic wishbone register bus.
*/
package phcd_pkg;

  // system clock
  localparam int CLK_MHZ = 20;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_B_SEL = 8'h08;
  localparam logic [7:0] IDX_A_SEL = 8'h09;
  localparam logic [7:0] IDX_STAT = 8'h0a;
  localparam logic [7:0] IDX_MCLK = 8'h0b;

  // field positions
  localparam int FREQ_W = 13;
  localparam int SEL_AUTODET_BIT = 15;
  localparam int SEL_AUTOSW_BIT = 14;
  localparam int SEL_GEN_BIT = 13;
  localparam int STAT_FAIL_A_BIT = 8;
  localparam int STAT_FAIL_B_BIT = 9;
  localparam int MCLK_ACTIVE_BIT = 13;

  // reset values
  localparam logic [15:0] SEL_RESET = 16'h92fb;
  localparam logic [FREQ_W-1:0] FREQ_DEFAULT = 13'h12fb;
  localparam logic ACTIVE_RESET = 1'b0;

  // detection timing
  localparam int CONSIST_PERIODS = 9;
  localparam int DETECT_TIME_US = 1125;
  localparam int CNT_W = 14;
  // bit clock declared lost after this long without a transition
  localparam int BCLK_LOSS_NS = 2000;
  localparam int BCLK_LOSS_CYC = (BCLK_LOSS_NS * CLK_MHZ + 999) / 1000;

  // highway select register, laid out as software sees it
  typedef struct packed {
    logic autodet;
    logic auto_sw;
    logic gen;
    logic [FREQ_W-1:0] freq;
  } phcd_sel_t;

  // result of one highway's detector
  typedef struct packed {
    logic load;
    logic [FREQ_W-1:0] code;
    logic fail;
  } phcd_det_t;

endpackage

//--- verilog/phcd_hwy_detect.sv
/*
  phcd_hwy_detect: one highway's bit clock measurement, loss monitor and frame
  sync generator. assumes bit clock and frame sync pins are synchronous to clk_i.
*/
`timescale 1ns/1ns
module phcd_hwy_detect
  import phcd_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic bclk_i, // highway bit clock pin
  input wire logic fs_ext_i, // external frame sync pin
  input wire phcd_pkg::phcd_sel_t cfg_i, // highway select register
  input wire logic restart_i, // restart detection, one cycle
  output logic fs_o, // generated frame sync level
  output logic fs_oe_o, // drive frame sync pin
  output phcd_pkg::phcd_det_t det_o // detector result
);
  import phcd_pkg::*;

  logic bclk_q_ff;
  logic fs_q_ff;
  logic seen_bclk_ff;
  logic seen_fs_ff;
  logic started_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] prev_ff;
  logic [3:0] match_ff;
  logic [7:0] loss_ff;
  logic fail_ff;
  logic load_ff;
  logic [FREQ_W-1:0] code_ff;
  logic [FREQ_W-1:0] gen_cnt_ff;
  logic gen_fs_ff;
  logic fs_src;
  logic bclk_rise;
  logic bclk_edge;
  logic fs_rise;
  logic fs_edge;
  logic [3:0] nxt_match;

  // bit clocks above half the system clock alias; they must not be measured here
  assign bclk_rise = bclk_i & ~bclk_q_ff;
  assign bclk_edge = bclk_i ^ bclk_q_ff;
  assign fs_src = cfg_i.gen ? gen_fs_ff : fs_ext_i;
  assign fs_rise = fs_src & ~fs_q_ff;
  assign fs_edge = fs_src ^ fs_q_ff;

  always_ff @(posedge clk_i)
  begin
    bclk_q_ff <= rst_i ? 1'b0 : bclk_i;
    fs_q_ff <= rst_i ? 1'b0 : fs_src;
  end

  // transitions on both inputs gate any result
  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart_i)
    begin
      seen_bclk_ff <= 1'b0;
      seen_fs_ff <= 1'b0;
    end
    else
    begin
      seen_bclk_ff <= seen_bclk_ff | bclk_edge;
      seen_fs_ff <= seen_fs_ff | fs_edge;
    end
  end

  // count bit clock rises per frame, accept after equal consecutive periods
  always_comb
  begin
    nxt_match = 4'h1;
    if (started_ff && cnt_ff == prev_ff && cnt_ff != '0)
    begin
      nxt_match = (match_ff == 4'(CONSIST_PERIODS)) ? match_ff : match_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart_i || fail_ff)
    begin
      cnt_ff <= '0;
      prev_ff <= '0;
      match_ff <= '0;
      started_ff <= 1'b0;
      load_ff <= 1'b0;
      code_ff <= FREQ_DEFAULT;
    end
    else if (fs_rise)
    begin
      cnt_ff <= bclk_rise ? CNT_W'(1) : '0;
      prev_ff <= cnt_ff;
      started_ff <= 1'b1;
      match_ff <= started_ff ? nxt_match : '0;
      // nine matching periods give at least 1.125 ms before any result
      load_ff <= started_ff && nxt_match == 4'(CONSIST_PERIODS)
                 && seen_bclk_ff && seen_fs_ff;
      code_ff <= FREQ_W'(cnt_ff - CNT_W'(1));
    end
    else
    begin
      load_ff <= 1'b0;
      if (bclk_rise && cnt_ff != {CNT_W{1'b1}})
      begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end

  // loss monitor on the bit clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i || bclk_edge)
    begin
      loss_ff <= '0;
      fail_ff <= 1'b0;
    end
    else if (loss_ff == 8'(BCLK_LOSS_CYC))
    begin
      fail_ff <= 1'b1;
    end
    else
    begin
      loss_ff <= loss_ff + 8'h01;
    end
  end

  // internal frame sync: one pulse every freq+1 bit clock rises
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cfg_i.gen)
    begin
      gen_cnt_ff <= '0;
      gen_fs_ff <= 1'b0;
    end
    else if (bclk_rise)
    begin
      gen_fs_ff <= (gen_cnt_ff == cfg_i.freq);
      gen_cnt_ff <= (gen_cnt_ff == cfg_i.freq) ? '0 : gen_cnt_ff + FREQ_W'(1);
    end
  end

  // gated: a pulse still in flight when generation is switched off never reaches
  // the released pin
  assign fs_o = gen_fs_ff & cfg_i.gen;
  assign fs_oe_o = cfg_i.gen;
  assign det_o = '{load: load_ff, code: code_ff, fail: fail_ff};

endmodule // phcd_hwy_detect

//--- dv/phcd_timing_model.sv
/* phcd_timing_model: far-side pcm timing source, one bit clock and frame sync.
   assumes clk_i paces it; a bit clock half period is five clk cycles. */
`timescale 1ns/1ns
module phcd_timing_model
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // reset, high
  input wire logic run_i, // bit clock running
  input wire logic [12:0] rises_i, // bit clocks per frame
  output logic bclk_o, // bit clock
  output logic fs_o // frame sync pulse
);
  logic [2:0] ph_ff;
  logic [12:0] cnt_ff;
  // a stopped clock stands still, so loss can be provoked from the bench
  always_ff @(posedge clk_i)
  begin
    fs_o <= 1'b0;
    if (rst_i)
    begin
      ph_ff <= 3'h0;
      cnt_ff <= 13'h0;
      bclk_o <= 1'b0;
    end
    else if (run_i)
    begin
      ph_ff <= (ph_ff == 3'h4) ? 3'h0 : ph_ff + 3'h1;
      if (ph_ff == 3'h4 && !bclk_o)
      begin
        cnt_ff <= (cnt_ff == rises_i - 13'h1) ? 13'h0 : cnt_ff + 13'h1;
        fs_o <= (cnt_ff == rises_i - 13'h1);
      end
      if (ph_ff == 3'h4)
        bclk_o <= ~bclk_o;
    end
  end
endmodule // phcd_timing_model

//--- dv/phcd_props.sv
/* phcd_props: port checks for phcd_top.
   assumes one clock domain with synchronous reset; bound to every phcd_top. */
`timescale 1ns/1ns
module phcd_props
  import phcd_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // reset, high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write
  input wire logic [31:0] dat_o, // read data
  input wire logic ack_o, // acknowledge
  input wire logic highway_a_bit_clock_i, // highway A bit clock
  input wire logic highway_a_frame_sync_o, // generated frame sync
  input wire logic highway_a_frame_sync_oe_o, // frame sync drive
  input wire logic active_highway_o, // active highway
  input wire logic a_clock_fail_flag_o, // A loss flag
  input wire logic b_clock_fail_flag_o // B loss flag
);
  localparam int LOSS = BCLK_LOSS_CYC;
  logic [5:0] cnt_a_ff;
  logic bclk_a_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles since the bit clock last moved; saturates so a long stop stays visible
  always_ff @(posedge clk_i)
  begin
    bclk_a_ff <= highway_a_bit_clock_i;
    if (rst_i || bclk_a_ff != highway_a_bit_clock_i)
      cnt_a_ff <= 6'h0;
    else if (cnt_a_ff != 6'h3f)
      cnt_a_ff <= cnt_a_ff + 6'h1;
  end
  AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_RD_UPPER: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0)
    else $error("upper read data not zero");
  AST_FS_DRIVE: assert property (highway_a_frame_sync_o |-> highway_a_frame_sync_oe_o)
    else $error("frame sync pulse on undriven pin");
  AST_FAIL_SET: assert property (cnt_a_ff == LOSS + 4 |-> a_clock_fail_flag_o)
    else $error("bit clock loss not flagged");
  AST_FAIL_EARLY: assert property ($rose(a_clock_fail_flag_o) |-> cnt_a_ff >= LOSS - 3)
    else $error("loss flagged too early");
  AST_FAIL_CLR: assert property (a_clock_fail_flag_o && bclk_a_ff != highway_a_bit_clock_i
    |-> ##[1:10] !a_clock_fail_flag_o) else $error("loss flag not cleared");
  AST_SWITCH: assert property ($rose(active_highway_o) |->
    (a_clock_fail_flag_o && !b_clock_fail_flag_o) || $past(ack_o && we_i))
    else $error("highway switched without cause");
  AST_RESET: assert property (disable iff (1'b0) rst_i |=> !ack_o && !active_highway_o
    && !a_clock_fail_flag_o && !highway_a_frame_sync_oe_o) else $error("bad reset state");
endmodule // phcd_props
bind phcd_top phcd_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .highway_a_bit_clock_i(highway_a_bit_clock_i),
  .highway_a_frame_sync_o(highway_a_frame_sync_o), .active_highway_o(active_highway_o),
  .highway_a_frame_sync_oe_o(highway_a_frame_sync_oe_o),
  .a_clock_fail_flag_o(a_clock_fail_flag_o), .b_clock_fail_flag_o(b_clock_fail_flag_o));

//--- dv/test_pcm_highway_clock_detect.sv
/* test_pcm_highway_clock_detect: self-checking bench for phcd_top.
   assumes a timing model on each highway and a 20 MHz clock. */
`timescale 1ns/1ns
module test_pcm_highway_clock_detect;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic a_run = 1'b0, b_run = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [3:0] be = 4'h3;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, a_bclk, a_fsm, a_fs, a_oe, b_bclk, b_fsm, b_fs, b_oe, act, fail_a, fail_b;
  // pin level: the block wins while it drives, else the source
  wire a_pin = a_oe ? a_fs : a_fsm;
  wire b_pin = b_oe ? b_fs : b_fsm;
  int errors = 0, compares = 0, cycles = 0;
  phcd_top DUT (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(wdat), .sel_i(be), .dat_o(rdat), .ack_o(ack), .highway_a_bit_clock_i(a_bclk),
    .highway_a_frame_sync_i(a_pin), .highway_a_frame_sync_o(a_fs),
    .highway_a_frame_sync_oe_o(a_oe), .redundant_bit_clock_i(b_bclk),
    .redundant_frame_sync_i(b_pin), .redundant_frame_sync_o(b_fs),
    .redundant_frame_sync_oe_o(b_oe), .active_highway_o(act),
    .a_clock_fail_flag_o(fail_a), .b_clock_fail_flag_o(fail_b));
  phcd_timing_model u_ma (.clk_i(clk), .rst_i(rst), .run_i(a_run), .rises_i(13'h100),
    .bclk_o(a_bclk), .fs_o(a_fsm));
  phcd_timing_model u_mb (.clk_i(clk), .rst_i(rst), .run_i(b_run), .rises_i(13'h080),
    .bclk_o(b_bclk), .fs_o(b_fsm));
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 80000)
    begin
      errors = errors + 1;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0);
    chk(rdat[15:0], e);
  endtask
  // rise-to-rise distance of a generated frame sync; the pulse lasts a whole
  // bit clock, so its high phase is passed before counting on to the next rise
  task automatic fs_period(input logic b, input logic [15:0] e);
    int n;
    n = 0;
    while ((b ? b_fs : a_fs) !== 1'b1)
      @(posedge clk);
    while ((b ? b_fs : a_fs) === 1'b1)
    begin
      @(posedge clk);
      n = n + 1;
    end
    while ((b ? b_fs : a_fs) !== 1'b1)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(n[15:0], e);
  endtask
  task automatic t_reset();
    rd(8'h24, 16'h92fb);
    rd(8'h20, 16'h92fb);
    rd(8'h2c, 16'h0000);
    rd(8'h3c, 16'h0000);
  endtask
  task automatic t_detect();
    b_run <= 1'b1;
    repeat (8960) @(posedge clk);
    rd(8'h20, 16'h92fb);
    repeat (6400) @(posedge clk);
    rd(8'h20, 16'h807f);
    rd(8'h24, 16'h92fb);
    a_run <= 1'b1;
    repeat (20480) @(posedge clk);
    rd(8'h24, 16'h92fb);
    repeat (10240) @(posedge clk);
    rd(8'h24, 16'h80ff);
  endtask
  task automatic t_sw();
    wb(1'b1, 8'h24, 16'h8000);
    rd(8'h24, 16'h92fb);
    wb(1'b1, 8'h24, 16'h0123);
    rd(8'h24, 16'h0123);
    be <= 4'h1;
    wb(1'b1, 8'h24, 16'hffaa);
    be <= 4'h3;
    rd(8'h24, 16'h01aa);
  endtask
  task automatic t_fail();
    wb(1'b1, 8'h24, 16'h00ff);
    a_run <= 1'b0;
    repeat (100) @(posedge clk);
    chk({15'h0, act}, 16'h0000);
    rd(8'h28, 16'h0100);
    wb(1'b1, 8'h24, 16'h40ff);
    repeat (4) @(posedge clk);
    chk({15'h0, act}, 16'h0001);
    rd(8'h2c, 16'h2000);
    a_run <= 1'b1;
    repeat (50) @(posedge clk);
    chk({15'h0, fail_a}, 16'h0000);
    wb(1'b1, 8'h2c, 16'h0000);
    rd(8'h2c, 16'h0000);
  endtask
  task automatic t_gen();
    wb(1'b1, 8'h24, 16'h203f);
    @(posedge clk);
    chk({15'h0, a_oe}, 16'h0001);
    fs_period(1'b0, 16'h0280);
    wb(1'b1, 8'h24, 16'h00ff);
    @(posedge clk);
    chk({15'h0, a_oe}, 16'h0000);
    wb(1'b1, 8'h20, 16'h203f);
    @(posedge clk);
    chk({15'h0, b_oe}, 16'h0001);
    fs_period(1'b1, 16'h0280);
    wb(1'b1, 8'h20, 16'h00ff);
    @(posedge clk);
    chk({15'h0, b_oe}, 16'h0000);
    b_run <= 1'b0;
    repeat (100) @(posedge clk);
    chk({15'h0, fail_b}, 16'h0001);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_detect();
    t_sw();
    t_fail();
    t_gen();
    test_done();
  end
endmodule // test_pcm_highway_clock_detect
